// ---- hw/mocf_top.sv ----
// Main oscillator control, startup wait and frequency meter with APB
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module mocf_top (
  // Clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       rst_b_i,
  // APB slave
  input  wire mocf_pkg::mocf_apb_req_type apb_req_i,
  output mocf_pkg::mocf_apb_rsp_type      apb_rsp_o,
  // Clock sources
  input  wire logic                       slow_clock_src_i,
  input  wire logic                       main_clock_src_i,
  // Oscillator controls
  output logic                            main_osc_enable_o,
  output logic                            osc_bypass_a_o,
  // Status
  output logic                            main_osc_stable_o,
  output logic                            freq_measure_done_o,
  output logic                            irq_o
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Clock source edges
  // ----------------------------------------------------------------
  logic slow_rise;
  logic slow_fall;
  logic main_rise;
  logic stable;

  // Slow clock is the permanent timebase, main clock the measured one
  mocf_edge_sync u_slow_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .level_i (slow_clock_src_i),
    .rise_o  (slow_rise),
    .fall_o  (slow_fall)
  );

  mocf_edge_sync u_main_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .level_i (main_clock_src_i),
    .rise_o  (main_rise),
    .fall_o  ()
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                  osc_en;
    logic                  bypass;
    logic [7:0]            osc_cnt;
    logic                  load;
    logic                  irq_mask;
    mocf_pkg::mocf_meas_type meas;
    logic [15:0]           freq;
    logic [3:0]            falls;
    logic                  done;
    logic                  irq;
    logic                  pready;
    logic                  pslverr;
    logic [31:0]           prdata;
  } mocf_top_state_type;

  mocf_top_state_type s_q;
  mocf_top_state_type s_d;

  logic setup;
  logic wr_acc;
  logic mapped;

  assign setup  = apb_req_i.psel & ~apb_req_i.penable;
  assign wr_acc = apb_req_i.psel & apb_req_i.penable & s_q.pready & apb_req_i.pwrite;

  always_comb begin
    unique case (apb_req_i.paddr)
      mocf_pkg::MAIN_OSC_REG_OFS,
      mocf_pkg::MAIN_FREQ_REG_OFS,
      mocf_pkg::POWER_STATUS_REG_OFS,
      mocf_pkg::POWER_IRQ_MASK_REG_OFS: mapped = 1'b1;
      default:                          mapped = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d      = s_q;
    s_d.load = 1'b0;

    // Zero wait state: answer in the access cycle
    s_d.pready  = setup;
    s_d.pslverr = setup & ~mapped;
    if (setup) begin
      s_d.prdata = mocf_pkg::RDATA_RST;
      if (!apb_req_i.pwrite) begin
        unique case (apb_req_i.paddr)
          mocf_pkg::MAIN_OSC_REG_OFS: begin
            s_d.prdata[mocf_pkg::OSC_EN_BIT]     = s_q.osc_en;
            s_d.prdata[mocf_pkg::OSC_BYPASS_BIT] = s_q.bypass;
            s_d.prdata[mocf_pkg::OSC_CNT_LSB +: mocf_pkg::OSC_CNT_W] = s_q.osc_cnt;
          end
          mocf_pkg::MAIN_FREQ_REG_OFS: begin
            s_d.prdata[mocf_pkg::FREQ_CNT_LSB +: mocf_pkg::FREQ_CNT_W] = s_q.freq;
            s_d.prdata[mocf_pkg::FREQ_DONE_BIT] = s_q.done;
          end
          mocf_pkg::POWER_STATUS_REG_OFS: begin
            s_d.prdata[mocf_pkg::STABLE_BIT] = stable;
          end
          mocf_pkg::POWER_IRQ_MASK_REG_OFS: begin
            s_d.prdata[mocf_pkg::STABLE_BIT] = s_q.irq_mask;
          end
          default: begin
            s_d.prdata = mocf_pkg::RDATA_RST;
          end
        endcase
      end
    end

    // Register writes take effect at the access edge
    if (wr_acc) begin
      unique case (apb_req_i.paddr)
        mocf_pkg::MAIN_OSC_REG_OFS: begin
          s_d.osc_en  = apb_req_i.pwdata[mocf_pkg::OSC_EN_BIT];
          // Bypass with enable low is software's duty
          s_d.bypass  = apb_req_i.pwdata[mocf_pkg::OSC_BYPASS_BIT];
          s_d.osc_cnt = apb_req_i.pwdata[mocf_pkg::OSC_CNT_LSB +: mocf_pkg::OSC_CNT_W];
          // Every enabling write restarts the wait
          s_d.load    = apb_req_i.pwdata[mocf_pkg::OSC_EN_BIT];
        end
        mocf_pkg::POWER_IRQ_MASK_REG_OFS: begin
          s_d.irq_mask = apb_req_i.pwdata[mocf_pkg::STABLE_BIT];
        end
        default: begin
          s_d.load = 1'b0;
        end
      endcase
    end

    s_d.irq = stable & s_q.irq_mask;

    // Frequency meter
    unique case (s_q.meas)
      mocf_pkg::MEAS_IDLE: begin
        if (stable) begin
          s_d.meas = mocf_pkg::MEAS_ARM;
        end
      end
      mocf_pkg::MEAS_ARM: begin
        if (!stable) begin
          s_d.meas = mocf_pkg::MEAS_IDLE;
        end else if (slow_rise) begin
          s_d.meas  = mocf_pkg::MEAS_COUNT;
          s_d.freq  = 16'h0000;
          s_d.falls = 4'h0;
        end
      end
      mocf_pkg::MEAS_COUNT: begin
        if (!stable) begin
          s_d.meas = mocf_pkg::MEAS_IDLE;
        end else begin
          if (main_rise) begin
            s_d.freq = s_q.freq + 16'h0001;
          end
          if (slow_fall) begin
            if (s_q.falls == mocf_pkg::MEAS_LAST_FALL) begin
              s_d.meas = mocf_pkg::MEAS_DONE;
              s_d.done = 1'b1;
            end else begin
              s_d.falls = s_q.falls + 4'h1;
            end
          end
        end
      end
      mocf_pkg::MEAS_DONE: begin
        // Result held until the oscillator is lost
        if (!stable) begin
          s_d.meas = mocf_pkg::MEAS_IDLE;
          s_d.done = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_q          <= '0;
      s_q.osc_en   <= mocf_pkg::OSC_EN_RST;
      s_q.bypass   <= mocf_pkg::OSC_BYPASS_RST;
      s_q.osc_cnt  <= mocf_pkg::OSC_CNT_RST;
      s_q.irq_mask <= mocf_pkg::IRQ_MASK_RST;
      s_q.meas     <= mocf_pkg::MEAS_IDLE;
      s_q.prdata   <= mocf_pkg::RDATA_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Startup countdown
  // ----------------------------------------------------------------
  mocf_startup u_startup (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n),
    .enable_i    (s_q.osc_en),
    .load_i      (s_q.load),
    .count_i     (s_q.osc_cnt),
    .slow_rise_i (slow_rise),
    .stable_o    (stable)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign apb_rsp_o.pready  = s_q.pready;
  assign apb_rsp_o.pslverr = s_q.pslverr;
  assign apb_rsp_o.prdata  = s_q.prdata;
  assign main_osc_enable_o   = s_q.osc_en;
  assign osc_bypass_a_o      = s_q.bypass;
  assign main_osc_stable_o   = stable;
  assign freq_measure_done_o = s_q.done;
  assign irq_o               = s_q.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  logic osc_wr;
  assign osc_wr = wr_acc && apb_req_i.paddr == mocf_pkg::MAIN_OSC_REG_OFS;

  a_reset_osc_off: assert property (
    $rose(rst_n) |-> !main_osc_enable_o && !main_osc_stable_o)
    else $error("Oscillator not off after reset");

  a_disable_clears_stable: assert property (
    osc_wr && !apb_req_i.pwdata[0] |-> ##2 !main_osc_stable_o)
    else $error("Stable flag kept after disable");

  a_enable_clears_stable: assert property (
    osc_wr && apb_req_i.pwdata[0] |=> s_q.load ##1 !main_osc_stable_o)
    else $error("Stable flag kept after enabling write");

  a_irq_follows_mask: assert property (
    ##1 irq_o == $past(stable && s_q.irq_mask))
    else $error("Interrupt does not follow stable and mask");

  a_count_waits_rise: assert property (
    s_q.meas == mocf_pkg::MEAS_ARM && stable && !slow_rise
    |=> s_q.meas == mocf_pkg::MEAS_ARM && $stable(s_q.freq))
    else $error("Meter started without slow rising edge");

  a_stop_at_sixteen: assert property (
    s_q.meas == mocf_pkg::MEAS_COUNT && stable && slow_fall && s_q.falls == 4'hF
    |=> freq_measure_done_o && s_q.meas == mocf_pkg::MEAS_DONE)
    else $error("Meter did not stop at sixteenth fall");

  a_done_holds_count: assert property (
    freq_measure_done_o && stable |=> $stable(s_q.freq))
    else $error("Measured count changed after done");

  a_main_edge_counts: assert property (
    s_q.meas == mocf_pkg::MEAS_COUNT && stable && main_rise
    |=> s_q.freq == $past(s_q.freq) + 16'h0001)
    else $error("Main clock edge not counted");

  a_disable_drops_stable: assert property (
    !main_osc_enable_o |=> !main_osc_stable_o)
    else $error("Stable flag set while oscillator off");

  a_status_reads_stable: assert property (
    setup && !apb_req_i.pwrite && apb_req_i.paddr == mocf_pkg::POWER_STATUS_REG_OFS
    |=> apb_rsp_o.prdata[mocf_pkg::STABLE_BIT] == $past(stable))
    else $error("Status read does not show stable flag");

  a_freq_reads_count: assert property (
    setup && !apb_req_i.pwrite && apb_req_i.paddr == mocf_pkg::MAIN_FREQ_REG_OFS
    |=> apb_rsp_o.prdata[15:0] == $past(s_q.freq)
    && apb_rsp_o.prdata[mocf_pkg::FREQ_DONE_BIT] == $past(s_q.done))
    else $error("Frequency read does not show count and done");

  a_meter_needs_stable: assert property (
    !stable |=> s_q.meas == mocf_pkg::MEAS_IDLE)
    else $error("Meter active without stable oscillator");

  a_bypass_from_write: assert property (
    osc_wr |=> osc_bypass_a_o == $past(apb_req_i.pwdata[mocf_pkg::OSC_BYPASS_BIT]))
    else $error("Bypass bit not taken from write");

  a_unmapped_error: assert property (
    setup && !mapped |=> apb_rsp_o.pready && apb_rsp_o.pslverr)
    else $error("Unmapped address not refused");

  a_ready_one_cycle: assert property (
    apb_rsp_o.pready |=> !apb_rsp_o.pready)
    else $error("Ready held beyond the access cycle");

  c_measure_done:   cover property ($rose(freq_measure_done_o));
  c_irq_raised:     cover property ($rose(irq_o));
  c_disable_in_run: cover property (s_q.meas == mocf_pkg::MEAS_COUNT ##1 !stable);
  c_restart_stable: cover property (osc_wr && stable);

endmodule : mocf_top

// ---- hw/mocf_pkg.sv ----
// Package for the main oscillator control and frequency meter block
package mocf_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] MAIN_OSC_REG_OFS       = 8'h20;
  localparam logic [7:0] MAIN_FREQ_REG_OFS      = 8'h24;
  localparam logic [7:0] POWER_STATUS_REG_OFS   = 8'h68;
  localparam logic [7:0] POWER_IRQ_MASK_REG_OFS = 8'h6C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int OSC_EN_BIT     = 0;
  localparam int OSC_BYPASS_BIT = 1;
  localparam int OSC_CNT_LSB    = 8;
  localparam int OSC_CNT_W      = 8;
  localparam int FREQ_CNT_LSB   = 0;
  localparam int FREQ_CNT_W     = 16;
  localparam int FREQ_DONE_BIT  = 16;
  localparam int STABLE_BIT     = 0;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic                 OSC_EN_RST     = 1'b0;
  localparam logic                 OSC_BYPASS_RST = 1'b0;
  localparam logic [OSC_CNT_W-1:0] OSC_CNT_RST    = 8'h00;
  localparam logic                 IRQ_MASK_RST   = 1'b0;
  localparam logic [2:0]           SLOW_DIV_LAST  = 3'h7;
  localparam logic [3:0]           MEAS_LAST_FALL = 4'hF;
  localparam logic [31:0]          RDATA_RST      = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MEAS_IDLE,
    MEAS_ARM,
    MEAS_COUNT,
    MEAS_DONE
  } mocf_meas_type;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } mocf_apb_req_type;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } mocf_apb_rsp_type;

endpackage : mocf_pkg

// ---- hw/mocf_edge_sync.sv ----
// Two-flop synchroniser with registered rise and fall pulses
`timescale 1ns/10ps
module mocf_edge_sync (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Sampled level and its edges
  input  wire logic level_i,
  output logic      rise_o,
  output logic      fall_o
);

  typedef struct packed {
    logic [1:0] fill;
    logic meta;
    logic sync;
    logic prev;
    logic rise;
    logic fall;
  } mocf_sync_state_type;

  mocf_sync_state_type s_q;
  mocf_sync_state_type s_d;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d      = s_q;
    s_d.meta = level_i;
    s_d.sync = s_q.meta;
    s_d.prev = s_q.sync;
    s_d.fill = (s_q.fill == 2'h3) ? s_q.fill : s_q.fill + 2'h1;
    // No edges until both stages hold real samples: a pin high at release is no edge
    // Edges only from the second stage onward
    s_d.rise = (s_q.fill == 2'h3) & s_q.sync & ~s_q.prev;
    s_d.fall = (s_q.fill == 2'h3) & ~s_q.sync & s_q.prev;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rise_o = s_q.rise;
  assign fall_o = s_q.fall;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_edge_from_sync: assert property (
    rise_o |-> $past(s_q.sync, 1) && !$past(s_q.prev, 1))
    else $error("Rise pulse without synchronised edge");

endmodule : mocf_edge_sync

// ---- hw/mocf_startup.sv ----
// Oscillator startup countdown on slow clock divided by eight
`timescale 1ns/10ps
module mocf_startup (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // Control from the register file
  input  wire logic       enable_i,
  input  wire logic       load_i,
  input  wire logic [7:0] count_i,
  // Slow clock rising edge pulse
  input  wire logic       slow_rise_i,
  // Oscillator stable flag
  output logic            stable_o
);

  typedef struct packed {
    logic       running;
    logic [2:0] div;
    logic [7:0] cnt;
    logic       stable;
  } mocf_start_state_type;

  mocf_start_state_type s_q;
  mocf_start_state_type s_d;

  // ----------------------------------------------------------------
  // Countdown
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    if (!enable_i) begin
      s_d.running = 1'b0;
      s_d.stable  = 1'b0;
    end else if (load_i) begin
      s_d.cnt     = count_i;
      s_d.div     = 3'h0;
      s_d.running = 1'b1;
      s_d.stable  = 1'b0;
    end else if (s_q.running && slow_rise_i) begin
      s_d.div = s_q.div + 3'h1;
      if (s_q.div == mocf_pkg::SLOW_DIV_LAST) begin
        // A count of zero still waits one divided period
        if (s_q.cnt <= 8'h01) begin
          s_d.cnt     = 8'h00;
          s_d.running = 1'b0;
          s_d.stable  = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt - 8'h01;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign stable_o = s_q.stable;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_load_takes_count: assert property (
    enable_i && load_i |=> s_q.cnt == $past(count_i) && s_q.running && !stable_o)
    else $error("Startup count not loaded");

  a_tick_decrements: assert property (
    enable_i && !load_i && s_q.running && slow_rise_i
    && s_q.div == 3'h7 && s_q.cnt > 8'h01
    |=> s_q.cnt == $past(s_q.cnt) - 8'h01 && !stable_o)
    else $error("Startup counter did not step down");

  a_zero_sets_stable: assert property (
    enable_i && !load_i && s_q.running && slow_rise_i
    && s_q.div == 3'h7 && s_q.cnt <= 8'h01 |=> stable_o && !s_q.running)
    else $error("Stable flag not set at zero");

  c_stable_reached: cover property ($rose(stable_o));

endmodule : mocf_startup

// ---- verification/mocf_osc_model.sv ----
// Clock source model: permanent slow clock and a gated main oscillator
`timescale 1ns/10ps
module mocf_osc_model #(
  parameter int SLOW_HALF = 20,
  parameter int MAIN_HALF = 4
) (
  // Reference clock
  input  wire logic clk_i,
  // Oscillator controls from the block
  input  wire logic enable_i,
  input  wire logic bypass_i,
  // Clock sources
  output logic      slow_clock_src_o,
  output logic      main_clock_src_o
);
  int slow_cnt;
  int main_cnt;

  initial begin
    slow_cnt = 0;
    main_cnt = 0;
    slow_clock_src_o = 1'b0;
    main_clock_src_o = 1'b0;
  end

  // Slow clock never stops, even in reset
  always @(posedge clk_i) begin
    if (slow_cnt == SLOW_HALF - 1) begin
      slow_cnt         <= 0;
      slow_clock_src_o <= ~slow_clock_src_o;
    end else begin
      slow_cnt <= slow_cnt + 1;
    end
  end

  // Main clock stands still unless oscillator or external source runs
  always @(posedge clk_i) begin
    if (!(enable_i || bypass_i)) begin
      main_cnt         <= 0;
      main_clock_src_o <= 1'b0;
    end else if (main_cnt == MAIN_HALF - 1) begin
      main_cnt         <= 0;
      main_clock_src_o <= ~main_clock_src_o;
    end else begin
      main_cnt <= main_cnt + 1;
    end
  end
endmodule : mocf_osc_model

// ---- verification/mocf_top_tb_top.sv ----
// Testbench for the oscillator control and frequency meter block
`timescale 1ns/10ps
module mocf_top_tb_top;
  localparam int SLOW_P = 40;
  localparam int MAIN_P = 8;
  localparam int LIMIT  = 20000;

  logic                       clk = 1'b0;
  logic                       rst_b = 1'b0;
  mocf_pkg::mocf_apb_req_type req = '0;
  mocf_pkg::mocf_apb_rsp_type rsp;
  logic                       slow_clk;
  logic                       main_clk;
  logic                       osc_en;
  logic                       bypass;
  logic                       stable;
  logic                       done;
  logic                       irq;
  int                         mismatches = 0;
  int                         n_checks = 0;
  int                         cyc = 0;

  always #4 clk = ~clk;

  mocf_top DUT (
    .clk_i               (clk),
    .rst_b_i             (rst_b),
    .apb_req_i           (req),
    .apb_rsp_o           (rsp),
    .slow_clock_src_i    (slow_clk),
    .main_clock_src_i    (main_clk),
    .main_osc_enable_o   (osc_en),
    .osc_bypass_a_o      (bypass),
    .main_osc_stable_o   (stable),
    .freq_measure_done_o (done),
    .irq_o               (irq)
  );

  mocf_osc_model #(.SLOW_HALF(SLOW_P/2), .MAIN_HALF(MAIN_P/2)) u_osc (
    .clk_i            (clk),
    .enable_i         (osc_en),
    .bypass_i         (bypass),
    .slow_clock_src_o (slow_clk),
    .main_clock_src_o (main_clk)
  );

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Master holds the request until pready is seen high at a rising edge
  task automatic apb(input logic is_wr, input logic [7:0] addr, input logic [31:0] wdata,
                     output logic [31:0] rdata, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= is_wr;
    req.paddr   <= addr;
    req.pwdata  <= wdata;
    @(posedge clk);
    req.penable <= 1'b1;
    // Values read just after an edge are those sampled at it
    @(posedge clk);
    while (rsp.pready !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    check({31'h0, rsp.pready}, 32'h0000_0001);
    rdata = rsp.prdata;
    err   = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    check({31'h0, e}, 32'h0000_0000);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    check(r, exp);
    check({31'h0, e}, 32'h0000_0000);
  endtask : rd_chk

  task automatic wait_flag(input int lim, input bit on_done, output int n);
    n = 0;
    while ((on_done ? done : stable) !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask : wait_flag

  function automatic logic [31:0] in_range(input int v, input int lo, input int hi);
    return {31'h0, (v >= lo && v <= hi)};
  endfunction : in_range

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    check({27'h0, osc_en, bypass, stable, done, irq}, 32'h0000_0000);
    rd_chk(mocf_pkg::MAIN_OSC_REG_OFS, 32'h0000_0000);
    rd_chk(mocf_pkg::POWER_STATUS_REG_OFS, 32'h0000_0000);
    rd_chk(mocf_pkg::MAIN_FREQ_REG_OFS, 32'h0000_0000);
    rd_chk(mocf_pkg::POWER_IRQ_MASK_REG_OFS, 32'h0000_0000);
    $display("test reset done");
  endtask : t_reset

  task automatic t_regs;
    logic [31:0] r;
    logic        e;
    wr(mocf_pkg::POWER_IRQ_MASK_REG_OFS, 32'h0000_0001);
    rd_chk(mocf_pkg::POWER_IRQ_MASK_REG_OFS, 32'h0000_0001);
    wr(mocf_pkg::MAIN_OSC_REG_OFS, 32'h0000_0002);
    @(negedge clk);
    check({30'h0, bypass, osc_en}, 32'h0000_0002);
    rd_chk(mocf_pkg::MAIN_OSC_REG_OFS, 32'h0000_0002);
    apb(1'b0, 8'h30, 32'h0000_0000, r, e);
    check({31'h0, e}, 32'h0000_0001);
    check(r, 32'h0000_0000);
    wr(mocf_pkg::MAIN_FREQ_REG_OFS, 32'hFFFF_FFFF);
    rd_chk(mocf_pkg::MAIN_FREQ_REG_OFS, 32'h0000_0000);
    check({31'h0, stable}, 32'h0000_0000);
    wr(mocf_pkg::MAIN_OSC_REG_OFS, 32'h0000_0000);
    $display("test registers done");
  endtask : t_regs

  task automatic t_startup;
    int          n;
    logic [31:0] r;
    logic        e;
    // Count of three covers three divided slow periods
    wr(mocf_pkg::MAIN_OSC_REG_OFS, 32'h0000_0301);
    wait_flag(30 * SLOW_P, 1'b0, n);
    check(in_range(n, 23 * SLOW_P, 25 * SLOW_P), 32'h0000_0001);
    rd_chk(mocf_pkg::POWER_STATUS_REG_OFS, 32'h0000_0001);
    repeat (2) @(negedge clk);
    check({31'h0, irq}, 32'h0000_0001);
    wait_flag(20 * SLOW_P, 1'b1, n);
    check(in_range(n, 15 * SLOW_P, 17 * SLOW_P + 10), 32'h0000_0001);
    apb(1'b0, mocf_pkg::MAIN_FREQ_REG_OFS, 32'h0000_0000, r, e);
    check({31'h0, r[16]}, 32'h0000_0001);
    // Window is 15.5 slow periods, rising edge to sixteenth fall, plus one edge of sync slack
    check(in_range(int'(r[15:0]), 15 * SLOW_P / MAIN_P, 16 * SLOW_P / MAIN_P + 1),
          32'h0000_0001);
    $display("test startup and measure done");
  endtask : t_startup

  task automatic t_restart;
    int n;
    wr(mocf_pkg::MAIN_OSC_REG_OFS, 32'h0000_0301);
    // Done falls one cycle after the stable flag
    repeat (3) @(negedge clk);
    check({30'h0, stable, done}, 32'h0000_0000);
    repeat (5 * SLOW_P) @(negedge clk);
    wr(mocf_pkg::MAIN_OSC_REG_OFS, 32'h0000_0000);
    repeat (2) @(negedge clk);
    check({30'h0, osc_en, stable}, 32'h0000_0000);
    repeat (30 * SLOW_P) @(negedge clk);
    check({30'h0, stable, irq}, 32'h0000_0000);
    // Zero count behaves as one divided period
    wr(mocf_pkg::MAIN_OSC_REG_OFS, 32'h0000_0001);
    wait_flag(12 * SLOW_P, 1'b0, n);
    check(in_range(n, 7 * SLOW_P, 9 * SLOW_P), 32'h0000_0001);
    repeat (2) @(negedge clk);
    check({31'h0, irq}, 32'h0000_0001);
    wr(mocf_pkg::POWER_IRQ_MASK_REG_OFS, 32'h0000_0000);
    repeat (2) @(negedge clk);
    check({30'h0, stable, irq}, 32'h0000_0002);
    wr(mocf_pkg::MAIN_OSC_REG_OFS, 32'h0000_0000);
    repeat (2) @(negedge clk);
    check({31'h0, stable}, 32'h0000_0000);
    $display("test restart and mask done");
  endtask : t_restart

  // ------------------------------------------------------------
  // Run control
  // ------------------------------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      mismatches = mismatches + 1;
      end_sim();
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_regs();
    t_startup();
    t_restart();
    end_sim();
  end
endmodule : mocf_top_tb_top
